// [common/twe_pkg.sv]
// Shared constants and types of the two-wire EEPROM host controller.
package twe_pkg;

  // Local clock and bus timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QCNT_W        = 8;
  // A quarter of the bus clock period; the rounding makes the bus slower, never faster.
  localparam logic [QCNT_W-1:0] QUARTER_CYC =
    QCNT_W'((SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS));

  // Longest self-timed write period of the device, used as the polling limit.
  localparam int SELF_TIMED_WRITE_PERIOD_MS = 5;
  localparam int SELF_TIMED_WRITE_CYC =
    (SELF_TIMED_WRITE_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  // Select word layout and bit counting.
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5; // Arbitrary value, set per system.
  localparam logic       RW_READ          = 1'b1;
  localparam logic       RW_WRITE         = 1'b0;
  localparam logic [3:0] ACK_BIT          = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT    = 4'h7;
  localparam logic [3:0] RECOVER_LAST_CLK = 4'h8;

  // Phases of one bus primitive.
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_HIGH  = 2'h2;
  localparam logic [1:0] PH_FALL  = 2'h3;

  typedef enum logic [1:0] {
    TWE_OP_WRITE,
    TWE_OP_READ_CUR,
    TWE_OP_READ_RAND,
    TWE_OP_RECOVER
  } twe_op_e;

  typedef struct packed {
    twe_op_e    op;
    logic       select_pin_high;
    logic       select_pin_low;
    logic [8:0] addr;
    logic [3:0] len_m1;
  } twe_cmd_s;

endpackage

// [design/twe_host.sv]
// Bus master that drives a two-wire serial EEPROM through its clock, data and protect pins.
//
// Contract
// - Data line changes only while clock is low, except start and stop.
// - Data falling with clock high is a start; one precedes every command.
// - Data rising with clock high is a stop; after reads device idles.
// - Recovery: start, nine clocks, start, stop; then device is ready.
// - Every start is followed by a select word with fixed type nibble; recovery follows its first start with nine clocks, its second with a stop.
// - Byte write: select, word address, one data byte, stop.
// - Page write sends up to fifteen more bytes, then a stop.
// - Poll with start and select until the device acknowledges.
// - Current read: one byte out, master withholds ack, then stop.
// - Random read: dummy write of address, repeated start, read select.
// - Sequential read: master acknowledges each byte to get the next.
// - Sequential read ends with withheld ack and a stop.
`timescale 1ns/1ps

module twe_host #(
  parameter int         TWR_CYC  = twe_pkg::SELF_TIMED_WRITE_CYC,
  parameter logic [3:0] DEV_TYPE = twe_pkg::DEV_TYPE_DEFAULT
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire twe_pkg::twe_cmd_s cmd,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [7:0]       wr_data,
  output logic                  rd_valid,
  output logic [7:0]            rd_data,
  output logic                  done,
  output logic                  err,
  input  wire logic             wp_req,
  output logic                  wp_pin,
  output logic                  scl,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe
);

  localparam int TW = $clog2(TWR_CYC + 1);

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_SEL, ST_ADDR, ST_WGET, ST_WDATA, ST_RSTART, ST_RSEL,
    ST_RDATA, ST_STOP, ST_PSTART, ST_PSEL, ST_PSTOP, ST_XCLK, ST_FINISH
  } twe_state_e;

  twe_state_e        state_q,  state_d;
  logic [1:0]        phase_q,  phase_d;
  logic [twe_pkg::QCNT_W-1:0] qcnt_q, qcnt_d;
  logic [3:0]        bit_q,    bit_d;
  logic [7:0]        shift_q,  shift_d;
  logic [3:0]        left_q,   left_d;
  twe_pkg::twe_cmd_s cmd_q,    cmd_d;
  logic              ack_q,    ack_d;
  logic              err_q,    err_d;
  logic [TW-1:0]     timer_q,  timer_d;
  logic              scl_q,    scl_d;
  logic              oe_q,     oe_d;
  logic [7:0]        rdat_q,   rdat_d;
  logic              rval_q,   rval_d;
  logic              done_q,   done_d;
  logic              wp_q,     wp_d;
  logic              sda_meta_q;
  logic              sda_s_q;

  logic tick;
  logic prim_done;
  logic is_start;
  logic is_stop;
  logic is_tx;
  logic drive_low;

  function automatic logic [7:0] sel_byte(input twe_pkg::twe_cmd_s c, input logic rw);
    // Type nibble, the two select pins, the page bit, then direction.
    sel_byte = {DEV_TYPE, c.select_pin_high, c.select_pin_low, c.addr[8], rw};
  endfunction

  assign cmd_ready = (state_q == ST_IDLE);
  assign wr_ready  = (state_q == ST_WGET);
  assign rd_valid  = rval_q;
  assign rd_data   = rdat_q;
  assign done      = done_q;
  assign err       = err_q;
  assign wp_pin    = wp_q;
  assign scl       = scl_q;
  assign sda_o     = 1'b0;
  assign sda_oe    = oe_q;

  always_comb begin
    tick      = (qcnt_q == twe_pkg::QUARTER_CYC - twe_pkg::QCNT_W'(1));
    prim_done = tick && (phase_q == twe_pkg::PH_FALL);
    is_start  = (state_q == ST_START) || (state_q == ST_RSTART) || (state_q == ST_PSTART);
    is_stop   = (state_q == ST_STOP) || (state_q == ST_PSTOP);
    is_tx     = (state_q == ST_SEL) || (state_q == ST_ADDR) || (state_q == ST_WDATA) ||
                (state_q == ST_RSEL) || (state_q == ST_PSEL);
    drive_low = 1'b0;
    if (is_tx) begin
      // Data bits go out MSB first; the ninth clock leaves the line to the device.
      drive_low = (bit_q == twe_pkg::ACK_BIT) ? 1'b0 : ~shift_q[7];
    end else if (state_q == ST_RDATA) begin
      // Acknowledge every byte but the last so the device keeps sending.
      drive_low = (bit_q == twe_pkg::ACK_BIT) && (left_q != 4'h0);
    end
  end

  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    qcnt_d  = qcnt_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    left_d  = left_q;
    cmd_d   = cmd_q;
    ack_d   = ack_q;
    err_d   = err_q;
    timer_d = (timer_q != '0) ? timer_q - TW'(1) : timer_q;
    rdat_d  = rdat_q;
    rval_d  = 1'b0;
    done_d  = 1'b0;
    wp_d    = wp_req;
    scl_d   = 1'b1;
    oe_d    = 1'b0;

    // Line levels: the clock is high in the middle two phases of a start or data primitive, and in the last three of a stop.
    if (is_start) begin
      scl_d = (phase_q == twe_pkg::PH_RISE) || (phase_q == twe_pkg::PH_HIGH);
      oe_d  = (phase_q == twe_pkg::PH_HIGH) || (phase_q == twe_pkg::PH_FALL);
    end else if (is_stop) begin
      scl_d = (phase_q != twe_pkg::PH_SETUP);
      oe_d  = (phase_q == twe_pkg::PH_SETUP) || (phase_q == twe_pkg::PH_RISE);
    end else if (state_q == ST_WGET) begin
      scl_d = 1'b0;
    end else if (state_q != ST_IDLE && state_q != ST_FINISH) begin
      // Data is set up in the low phase and held across the high phases.
      scl_d = (phase_q == twe_pkg::PH_RISE) || (phase_q == twe_pkg::PH_HIGH);
      oe_d  = drive_low;
    end

    if (state_q != ST_IDLE && state_q != ST_WGET && state_q != ST_FINISH) begin
      qcnt_d = tick ? '0 : qcnt_q + twe_pkg::QCNT_W'(1);
      if (tick) begin
        phase_d = phase_q + 2'h1;
      end
    end

    // Sample at the end of the high time, just before the clock falls, long after the synchroniser settles.
    if (tick && phase_q == twe_pkg::PH_HIGH && !is_start && !is_stop) begin
      if (bit_q == twe_pkg::ACK_BIT) begin
        ack_d = ~sda_s_q;
      end else if (state_q == ST_RDATA) begin
        shift_d = {shift_q[6:0], sda_s_q};
      end
    end

    unique case (state_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          cmd_d   = cmd;
          left_d  = cmd.len_m1;
          err_d   = 1'b0;
          phase_d = twe_pkg::PH_SETUP;
          qcnt_d  = '0;
          bit_d   = 4'h0;
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (prim_done) begin
          bit_d = 4'h0;
          if (cmd_q.op == twe_pkg::TWE_OP_RECOVER) begin
            state_d = ST_XCLK;
          end else begin
            // A current read goes straight to the read select word.
            shift_d = sel_byte(cmd_q, (cmd_q.op == twe_pkg::TWE_OP_READ_CUR) ?
                               twe_pkg::RW_READ : twe_pkg::RW_WRITE);
            state_d = ST_SEL;
          end
        end
      end
      ST_RSTART: begin
        if (prim_done) begin
          bit_d   = 4'h0;
          shift_d = sel_byte(cmd_q, twe_pkg::RW_READ);
          state_d = (cmd_q.op == twe_pkg::TWE_OP_RECOVER) ? ST_STOP : ST_RSEL;
        end
      end
      ST_PSTART: begin
        if (prim_done) begin
          bit_d   = 4'h0;
          shift_d = sel_byte(cmd_q, twe_pkg::RW_WRITE);
          state_d = ST_PSEL;
        end
      end
      ST_WGET: begin
        if (wr_valid) begin
          shift_d = wr_data;
          bit_d   = 4'h0;
          phase_d = twe_pkg::PH_SETUP;
          qcnt_d  = '0;
          state_d = ST_WDATA;
        end
      end
      ST_SEL, ST_ADDR, ST_WDATA, ST_RSEL, ST_PSEL, ST_RDATA, ST_XCLK: begin
        if (prim_done) begin
          if (bit_q != twe_pkg::ACK_BIT) begin
            bit_d = bit_q + 4'h1;
            if (is_tx) begin
              shift_d = {shift_q[6:0], 1'b0};
            end
            if (state_q == ST_RDATA && bit_q == twe_pkg::LAST_DATA_BIT) begin
              rdat_d = shift_q;
              rval_d = 1'b1;
            end
          end else begin
            bit_d = 4'h0;
            unique case (state_q)
              ST_SEL: begin
                if (!ack_q) begin
                  err_d   = 1'b1;
                  state_d = ST_STOP;
                end else if (cmd_q.op == twe_pkg::TWE_OP_READ_CUR) begin
                  state_d = ST_RDATA;
                end else begin
                  shift_d = cmd_q.addr[7:0];
                  state_d = ST_ADDR;
                end
              end
              ST_ADDR: begin
                if (!ack_q) begin
                  err_d   = 1'b1;
                  state_d = ST_STOP;
                end else begin
                  // Random reads only load the address, then turn around.
                  state_d = (cmd_q.op == twe_pkg::TWE_OP_READ_RAND) ? ST_RSTART : ST_WGET;
                end
              end
              ST_WDATA: begin
                if (!ack_q) begin
                  err_d   = 1'b1;
                  state_d = ST_STOP;
                end else if (left_q == 4'h0) begin
                  state_d = ST_STOP;
                end else begin
                  // At most sixteen bytes per command, so the page never wraps onto itself.
                  left_d  = left_q - 4'h1;
                  state_d = ST_WGET;
                end
              end
              ST_RSEL: begin
                if (!ack_q) begin
                  err_d   = 1'b1;
                  state_d = ST_STOP;
                end else begin
                  state_d = ST_RDATA;
                end
              end
              ST_PSEL: begin
                state_d = ST_PSTOP;
              end
              ST_RDATA: begin
                if (left_q == 4'h0) begin
                  state_d = ST_STOP;
                end else begin
                  left_d = left_q - 4'h1;
                end
              end
              ST_XCLK: begin
                state_d = ST_RSTART;
              end
              default: begin
                state_d = ST_STOP;
              end
            endcase
          end
          if (state_q == ST_XCLK && bit_q == twe_pkg::RECOVER_LAST_CLK) begin
            bit_d = 4'h0;
          end
        end
      end
      ST_STOP: begin
        if (prim_done) begin
          if (cmd_q.op == twe_pkg::TWE_OP_WRITE && !err_q) begin
            timer_d = TW'(TWR_CYC);
            state_d = ST_PSTART;
          end else begin
            state_d = ST_FINISH;
          end
        end
      end
      ST_PSTOP: begin
        if (prim_done) begin
          if (ack_q) begin
            state_d = ST_FINISH;
          end else if (timer_q == '0) begin
            err_d   = 1'b1;
            state_d = ST_FINISH;
          end else begin
            state_d = ST_PSTART;
          end
        end
      end
      ST_FINISH: begin
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      phase_q    <= twe_pkg::PH_SETUP;
      qcnt_q     <= '0;
      bit_q      <= 4'h0;
      shift_q    <= 8'h00;
      left_q     <= 4'h0;
      cmd_q      <= '0;
      ack_q      <= 1'b0;
      err_q      <= 1'b0;
      timer_q    <= '0;
      scl_q      <= 1'b1;
      oe_q       <= 1'b0;
      rdat_q     <= 8'h00;
      rval_q     <= 1'b0;
      done_q     <= 1'b0;
      wp_q       <= 1'b0;
      sda_meta_q <= 1'b1;
      sda_s_q    <= 1'b1;
    end else begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      qcnt_q     <= qcnt_d;
      bit_q      <= bit_d;
      shift_q    <= shift_d;
      left_q     <= left_d;
      cmd_q      <= cmd_d;
      ack_q      <= ack_d;
      err_q      <= err_d;
      timer_q    <= timer_d;
      scl_q      <= scl_d;
      oe_q       <= oe_d;
      rdat_q     <= rdat_d;
      rval_q     <= rval_d;
      done_q     <= done_d;
      wp_q       <= wp_d;
      sda_meta_q <= sda_i;
      sda_s_q    <= sda_meta_q;
    end
  end

endmodule

// [bench/twe_host_checker.sv]
// Protocol checker bound to the two-wire EEPROM host.
`timescale 1ns/1ps
module twe_host_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rd_valid,
  input wire logic done,
  input wire logic err,
  input wire logic wp_req,
  input wire logic wp_pin,
  input wire logic scl,
  input wire logic sda_oe
);
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Reset counts as a long idle so a command right after release is not flagged.
  always_comb hi_d = !scl ? 8'h00 : (hi_q == 8'hFF ? hi_q : hi_q + 8'h01);
  always_ff @(posedge mclk) hi_q <= nrst ? hi_d : 8'hFF;
  property p_cond_mid; $changed(sda_oe) && scl |-> $past(scl, 100); endproperty
  a_cond_mid: assert property (p_cond_mid) else $error("data moved early in clock high");
  property p_start; $fell(cmd_ready) |-> ##[240:270] (scl && sda_oe); endproperty
  a_start: assert property (p_start) else $error("no start after command");
  property p_stop_idle; $fell(sda_oe) && scl |-> scl [*8]; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("clock moved after stop");
  property p_reset;
    disable iff (1'b0) !nrst |=> scl && !sda_oe && cmd_ready && !done && !rd_valid && !err;
  endproperty
  a_reset: assert property (p_reset) else $error("bus not idle in reset");
  property p_err_clear; $fell(cmd_ready) |=> !err; endproperty
  a_err_clear: assert property (p_err_clear) else $error("error kept after new command");
  property p_done; done |-> scl && !sda_oe && cmd_ready; endproperty
  a_done: assert property (p_done) else $error("done with bus still busy");
  property p_rd_busy; rd_valid |-> !cmd_ready && !done; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read byte outside a command");
  property p_scl_high; $fell(scl) |-> hi_q >= 8'h78; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  property p_wp; $past(nrst) |-> wp_pin == $past(wp_req); endproperty
  a_wp: assert property (p_wp) else $error("protect pin not following request");
  c_err: cover property (done && err);
  c_rd: cover property (rd_valid);
  c_wp: cover property ($rose(wp_pin));
endmodule
bind twe_host twe_host_checker u_chk (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .rd_valid(rd_valid), .done(done), .err(err), .wp_req(wp_req),
  .wp_pin(wp_pin), .scl(scl), .sda_oe(sda_oe));

// [bench/twe_eeprom_model.sv]
// Behavioural two-wire EEPROM that answers the host on the far side of the bus.
`timescale 1ns/1ps
module twe_eeprom_model #(
  parameter logic [3:0] DEV_TYPE = 4'h5,
  parameter logic       PIN_HI   = 1'b1,
  parameter logic       PIN_LO   = 1'b0,
  parameter int         TWR_NS   = 30000
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic wp,
  output logic      dev_oe
);
  logic [7:0] mem [512];
  logic [7:0] sh;
  logic [8:0] ctr;
  int         state;
  int         bitn;
  int         nw;
  realtime    busy_end;
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
    ctr = 9'h000;
    state = 0;
    bitn = 0;
    nw = 0;
    busy_end = 0;
    dev_oe = 1'b0;
  end
  always @(negedge sda) if (scl) begin
    state = 1;
    bitn = 0;
    nw = 0;
  end
  always @(posedge sda) if (scl) begin
    if (state == 3 && nw > 0) busy_end = $realtime + TWR_NS;
    state = 0;
  end
  always @(posedge scl) if (state != 0) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (state == 4 && sda) state = 0;
    bitn = bitn + 1;
  end
  // Acknowledge is decided first and driven once, so the line never glitches.
  always @(negedge scl) if (state != 0) begin
    if (bitn == 8) begin
      if (state == 1) begin
        if (sh[7:4] != DEV_TYPE || sh[3:2] != {PIN_HI, PIN_LO} || $realtime < busy_end) begin
          state = 0;
        end else if (!sh[0]) ctr[8] = sh[1];
      end else if (state == 2) ctr[7:0] = sh;
      else if (state == 3) begin
        if (!(wp && ctr[8])) mem[ctr] = sh;
        ctr[3:0] = ctr[3:0] + 4'h1;
        nw = nw + 1;
      end else ctr = ctr + 9'h001;
      dev_oe = (state inside {1, 2, 3});
    end else if (bitn == 9) begin
      bitn = 0;
      if (state == 1) state = sh[0] ? 4 : 2;
      else if (state == 2) state = 3;
      dev_oe = (state == 4) && !mem[ctr][7];
    end else if (state == 4) dev_oe = !mem[ctr][7 - bitn];
  end
endmodule

// [bench/test_twe_host.sv]
// Self-checking bench for the two-wire EEPROM host against a behavioural device.
`timescale 1ns/1ps
module test_twe_host;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  logic              cmd_valid = 1'b0;
  logic              cmd_ready;
  twe_pkg::twe_cmd_s cmd = '0;
  logic              wr_valid = 1'b0;
  logic              wr_ready;
  logic [7:0]        wr_data = 8'h00;
  logic              rd_valid;
  logic [7:0]        rd_data;
  logic              done;
  logic              err;
  logic              wp_req = 1'b0;
  logic              wp_rand = 1'b0;
  logic              wp_pin;
  logic              scl;
  logic              sda_oe;
  logic              dev_oe;
  wire               sda = !(sda_oe || dev_oe);
  logic [31:0]       seed = 32'h78E4CCC1;
  logic [7:0]        wq[$];
  logic [7:0]        rq[$];
  logic [7:0]        d0;
  int                fails = 0;
  int                total_checks = 0;
  int                cycles = 0;
  twe_host #(.TWR_CYC(20000)) u_dut (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .err(err),
    .wp_req(wp_req), .wp_pin(wp_pin), .scl(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  twe_eeprom_model #(.DEV_TYPE(twe_pkg::DEV_TYPE_DEFAULT)) u_dev (.scl(scl), .sda(sda),
    .wp(wp_pin), .dev_oe(dev_oe));
  always #2.5 mclk = !mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] init_val(input logic [8:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input twe_pkg::twe_op_e op, input logic [8:0] a, input logic [3:0] n,
                     input logic pin_lo);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, select_pin_high: 1'b1, select_pin_low: pin_lo, addr: a, len_m1: n};
    @(posedge mclk);
    while (cmd_ready !== 1'b1) @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    while (done !== 1'b1) @(posedge mclk);
    $display("test %0d ended", op);
  endtask
  // Write bytes are offered as a level and held until the host takes each one.
  always @(posedge mclk) begin
    cycles++;
    seed <= lfsr(seed);
    wp_req <= wp_rand & seed[9];
    if (rd_valid) rq.push_back(rd_data);
    if (wr_valid && wr_ready) void'(wq.pop_front());
    wr_valid <= wq.size() != 0;
    wr_data <= wq.size() != 0 ? wq[0] : seed[7:0];
    // The six commands, write polling included, need about 86000 cycles.
    if (cycles == 99000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    d0 = seed[7:0];
    wq.push_back(d0);
    wq.push_back(seed[15:8]);
    run(twe_pkg::TWE_OP_WRITE, 9'h1FF, 4'h1, 1'b0);
    check(8'(err), 8'h00);
    wp_rand = 1'b1;
    run(twe_pkg::TWE_OP_READ_CUR, 9'h1F1, 4'h0, 1'b0);
    check(rq.pop_front(), init_val(9'h1F1));
    run(twe_pkg::TWE_OP_READ_RAND, 9'h1FF, 4'h1, 1'b0);
    check(rq.pop_front(), d0);
    check(rq.pop_front(), init_val(9'h000));
    run(twe_pkg::TWE_OP_READ_CUR, 9'h001, 4'h0, 1'b1);
    check(8'(err), 8'h01);
    check(8'(rq.size()), 8'h00);
    run(twe_pkg::TWE_OP_RECOVER, 9'h000, 4'h0, 1'b0);
    check(8'(err), 8'h00);
    run(twe_pkg::TWE_OP_READ_CUR, 9'h001, 4'h0, 1'b0);
    check(rq.pop_front(), init_val(9'h001));
    report_and_stop();
  end
endmodule
